// [logic/wwd_pkg.sv]
// Package of constants and types for the window watchdog.
package wwd_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [11:0] WWD_BLOCKING_BASE = 12'h200;
    localparam logic [11:0] WWD_NONBLOCKING_BASE = 12'h300;
    localparam logic [7:0] WWD_TIMEOUT_CONFIG_OFS = 8'h10;
    localparam logic [7:0] WWD_SERVICE_OFS = 8'h11;
    localparam logic [7:0] WWD_TIMEOUT_CONFIG_RST = 8'h00;
    localparam logic [7:0] WWD_SERVICE_RST = 8'h00;
    localparam int WWD_EXT_DISABLE_BIT = 7;
    localparam int WWD_WINDOW_OPEN_BIT = 6;
    localparam int WWD_TIMEOUT_SEL_MSB = 2;
    localparam logic [7:0] WWD_FIRST_KEY = 8'hAA;
    localparam logic [7:0] WWD_SECOND_KEY = 8'h55;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam longint WWD_CLK_HZ = 25000000;
    localparam longint WWD_BASE_TIMEOUT_MS = 10;
    localparam longint WWD_INITIAL_TIMEOUT_MS = 256;
    localparam longint WWD_BASE_TIMEOUT_CYCLES = WWD_BASE_TIMEOUT_MS * WWD_CLK_HZ / 1000;
    localparam longint WWD_INITIAL_TIMEOUT_CYCLES = WWD_INITIAL_TIMEOUT_MS * WWD_CLK_HZ / 1000;
    localparam int WWD_CNT_W = 32;

    typedef enum logic [1:0] {
        WWD_OFF,
        WWD_INITIAL,
        WWD_WINDOW
    } wwd_state_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic nonblocking;
        logic [7:0] offset;
        logic [7:0] wdata;
    } wwd_req_type;
endpackage

// [logic/wwd_window_watchdog.sv]
// Window watchdog with initial fixed timeout and alternating-key servicing.
`timescale 1ns/1ns
// Function
// - Watchdog runs only in Normal mode
// - Counter clocked from own base clock
// - Timeout select doubles from 10 ms
// - Stop-mode read shows external disable set
// - Initial phase fixed timeout, window flag set
// - AA before initial timeout, else reset
// - Window mode: service only in second half
// - Window flag shows open service window
// - Timeout or wrong value gives reset
// - Test voltage keeps watchdog disabled, flagged
// - Disable clears service; restart initial sequence
// - Low power clears service register
// - Bits 7,6 status; 5..3 read zero
// - Decode at blocking and non-blocking bases
// - Correct open-window service restarts counter
module wwd_window_watchdog #(
    parameter longint INITIAL_TIMEOUT_CYCLES = wwd_pkg::WWD_INITIAL_TIMEOUT_CYCLES,
    parameter longint BASE_TIMEOUT_CYCLES = wwd_pkg::WWD_BASE_TIMEOUT_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire wwd_pkg::wwd_req_type i_req,
    input wire logic i_normal_mode,
    input wire logic i_stop_mode,
    input wire logic i_test_disable_voltage,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic o_wd_reset
);
    import wwd_pkg::*;

    // ************************************************************
    // Pin synchroniser for the external disable condition
    // ************************************************************
    logic [2:0] dis_sync_q;
    logic ext_dis_q;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            dis_sync_q <= 3'h0;
            ext_dis_q <= 1'b0;
        end
        else
        begin
            dis_sync_q <= {dis_sync_q[1:0], i_test_disable_voltage};
            if (dis_sync_q[2] == dis_sync_q[1])
            begin
                ext_dis_q <= dis_sync_q[2];
            end
        end
    end

    // ************************************************************
    // Register decode
    // ************************************************************
    logic hit_cfg;
    logic hit_svc;
    logic [7:0] req_abs;
    // The offset is relative to whichever base the access used; both map here.
    assign req_abs = i_req.offset;
    assign hit_cfg = (req_abs == WWD_TIMEOUT_CONFIG_OFS);
    assign hit_svc = (req_abs == WWD_SERVICE_OFS);

    logic [2:0] timeout_sel_q;
    logic [7:0] service_q;
    wwd_state_type state_q;
    logic [WWD_CNT_W-1:0] cnt_q;
    logic wd_active;
    logic svc_wr;
    logic [WWD_CNT_W-1:0] limit;
    logic [WWD_CNT_W-1:0] half;
    logic win_open;
    logic expect_aa_q;
    logic [7:0] expected;

    // Only Normal mode with no external disable runs the counter.
    assign wd_active = i_normal_mode && !ext_dis_q;
    assign svc_wr = i_req.wr && hit_svc && wd_active;
    assign limit = WWD_CNT_W'(BASE_TIMEOUT_CYCLES) << timeout_sel_q;
    assign half = limit >> 1;
    assign win_open = (state_q == WWD_INITIAL) || (state_q == WWD_OFF) ||
        ((state_q == WWD_WINDOW) && (cnt_q >= half));
    assign expected = expect_aa_q ? WWD_FIRST_KEY : WWD_SECOND_KEY;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            timeout_sel_q <= WWD_TIMEOUT_CONFIG_RST[WWD_TIMEOUT_SEL_MSB:0];
        end
        else if (i_req.wr && hit_cfg)
        begin
            // Stored at once, but only used once window mode starts.
            timeout_sel_q <= i_req.wdata[WWD_TIMEOUT_SEL_MSB:0];
        end
    end

    // ************************************************************
    // Watchdog sequencer
    // ************************************************************
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            state_q <= WWD_INITIAL;
            cnt_q <= '0;
            service_q <= WWD_SERVICE_RST;
            expect_aa_q <= 1'b1;
            o_wd_reset <= 1'b0;
        end
        else
        begin
            o_wd_reset <= 1'b0;
            if (!wd_active)
            begin
                // Low power halts the counter; any disable restarts the sequence.
                state_q <= WWD_OFF;
                cnt_q <= '0;
                service_q <= WWD_SERVICE_RST;
                expect_aa_q <= 1'b1;
            end
            else
            begin
                case (state_q)
                    WWD_OFF,
                    WWD_INITIAL:
                    begin
                        // The first active cycle after a disable already belongs to the
                        // initial phase, so a service write there is judged as well.
                        if (svc_wr)
                        begin
                            service_q <= i_req.wdata;
                            cnt_q <= '0;
                            if (i_req.wdata == WWD_FIRST_KEY)
                            begin
                                state_q <= WWD_WINDOW;
                                expect_aa_q <= 1'b0;
                            end
                            else
                            begin
                                o_wd_reset <= 1'b1;
                                state_q <= WWD_INITIAL;
                                expect_aa_q <= 1'b1;
                            end
                        end
                        else if (cnt_q >= WWD_CNT_W'(INITIAL_TIMEOUT_CYCLES) - 1'b1)
                        begin
                            o_wd_reset <= 1'b1;
                            state_q <= WWD_INITIAL;
                            cnt_q <= '0;
                        end
                        else
                        begin
                            state_q <= WWD_INITIAL;
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end
                    WWD_WINDOW:
                    begin
                        if (svc_wr)
                        begin
                            service_q <= i_req.wdata;
                            cnt_q <= '0;
                            if (win_open && (i_req.wdata == expected))
                            begin
                                expect_aa_q <= !expect_aa_q;
                            end
                            else
                            begin
                                o_wd_reset <= 1'b1;
                                state_q <= WWD_INITIAL;
                                expect_aa_q <= 1'b1;
                            end
                        end
                        else if (cnt_q >= limit - 1'b1)
                        begin
                            o_wd_reset <= 1'b1;
                            state_q <= WWD_INITIAL;
                            cnt_q <= '0;
                            expect_aa_q <= 1'b1;
                        end
                        else
                        begin
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end
                    default:
                    begin
                        state_q <= WWD_INITIAL;
                        cnt_q <= '0;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    logic ext_flag;
    assign ext_flag = ext_dis_q || i_stop_mode;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            o_rdata <= 8'h00;
            o_rvalid <= 1'b0;
        end
        else
        begin
            o_rvalid <= i_req.rd;
            if (i_req.rd && hit_cfg)
            begin
                o_rdata <= {ext_flag, win_open && wd_active, 3'h0, timeout_sel_q};
            end
            else if (i_req.rd && hit_svc)
            begin
                o_rdata <= service_q;
            end
            else
            begin
                o_rdata <= 8'h00;
            end
        end
    end
endmodule

// [tb/wwd_properties.sv]
// Port checker of the window watchdog.
`timescale 1ns/1ns
module wwd_properties
import wwd_pkg::*;
#(
    parameter longint INITIAL_TIMEOUT_CYCLES = 200,
    parameter longint BASE_TIMEOUT_CYCLES = 20
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire wwd_pkg::wwd_req_type i_req,
    input wire logic i_normal_mode,
    input wire logic i_stop_mode,
    input wire logic i_test_disable_voltage,
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic o_wd_reset
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic cfg_rd = i_req.rd && i_req.offset == WWD_TIMEOUT_CONFIG_OFS;
    sequence s_bad_key;
        i_normal_mode && !i_stop_mode && !i_test_disable_voltage
            && !$past(i_test_disable_voltage, 5) && i_req.wr
            && i_req.offset == WWD_SERVICE_OFS && i_req.wdata != WWD_FIRST_KEY
            && i_req.wdata != WWD_SECOND_KEY;
    endsequence
    sequence s_stop_read;
        i_stop_mode ##1 (i_stop_mode && cfg_rd);
    endsequence
    a_bad_key: assert property (s_bad_key |=> o_wd_reset)
        else $error("no watchdog reset after a wrong key");
    a_read_answer: assert property (i_req.rd |=> o_rvalid)
        else $error("read not answered");
    a_no_stray: assert property (!i_req.rd |=> !o_rvalid)
        else $error("read answer without a read");
    a_zero_field: assert property (cfg_rd |=> o_rdata[5:3] == 3'h0)
        else $error("config bits 5 to 3 not zero");
    a_reset_single: assert property (o_wd_reset |=> !o_wd_reset)
        else $error("watchdog reset longer than one cycle");
    a_stop_flag: assert property (s_stop_read |=> o_rdata[WWD_EXT_DISABLE_BIT])
        else $error("stop mode read without off flag");
    a_idle_quiet: assert property ((!i_normal_mode)[*2] |=> !o_wd_reset)
        else $error("watchdog reset outside normal mode");
    a_vtest_quiet: assert property (i_test_disable_voltage[*6] |=> !o_wd_reset)
        else $error("watchdog reset while disabled");
endmodule

// [tb/wwd_mcu_model.sv]
// Microcontroller model issuing register accesses.
`timescale 1ns/1ns
module wwd_mcu_model
import wwd_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output wwd_pkg::wwd_req_type o_req
);
    initial o_req = '0;
    task automatic acc(input logic w, input logic nb, input logic [7:0] ofs,
        input logic [7:0] d, output logic [7:0] q);
        @(negedge i_ref_clk);
        o_req = '{wr: w, rd: !w, nonblocking: nb, offset: ofs, wdata: d};
        @(negedge i_ref_clk);
        o_req = '0;
        q = i_rvalid ? i_rdata : 8'hXX;
    endtask
endmodule

// [tb/test_window_watchdog.sv]
// Self-checking testbench of the window watchdog.
`timescale 1ns/1ns
module test_window_watchdog;
    import wwd_pkg::*;
    typedef struct packed {logic nb; logic [7:0] ofs; logic [7:0] wd; logic [7:0] ex;} wwd_row_type;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic nm = 1'b1;
    logic sm = 1'b0;
    logic tv = 1'b0;
    wwd_req_type req;
    logic [7:0] rdata;
    logic rvalid;
    logic wd_reset;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int nrst = 0;
    int mark;
    int n;
    logic [7:0] q;
    wwd_row_type rows [3] = '{'{1'b0, 8'h10, 8'hFF, 8'h47}, '{1'b1, 8'h10, 8'h05, 8'h45},
        '{1'b0, 8'h20, 8'h00, 8'h00}};
    wwd_window_watchdog #(.INITIAL_TIMEOUT_CYCLES(200), .BASE_TIMEOUT_CYCLES(20)) i_dut (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_req(req), .i_normal_mode(nm),
        .i_stop_mode(sm), .i_test_disable_voltage(tv), .o_rdata(rdata), .o_rvalid(rvalid),
        .o_wd_reset(wd_reset));
    wwd_mcu_model i_mcu (.i_ref_clk(i_ref_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
    initial forever #20 i_ref_clk = ~i_ref_clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] ex);
        cmp_count++;
        if (got !== ex)
        begin
            err_count++;
            $display("FAIL %0t got %h expected %h", $time, got, ex);
        end
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        i_mcu.acc(1'b1, 1'b0, ofs, d, q);
    endtask
    task automatic rdb(input int b, input logic e);
        i_mcu.acc(1'b0, 1'b0, 8'h10, 8'h00, q);
        chk(8'(q[b]), 8'(e));
    endtask
    task automatic gap(input int c);
        repeat (c) @(negedge i_ref_clk);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // A pulse is counted at the edge after it rises, so counts never race the design.
    always @(posedge i_ref_clk)
    begin
        cyc++;
        if (wd_reset === 1'b1)
            nrst++;
        if (cyc == 5000)
        begin
            err_count++;
            summarize();
        end
    end
    initial
    begin
        gap(16);
        i_rst_n = 1'b1;
        foreach (rows[k])
        begin
            i_mcu.acc(1'b1, rows[k].nb, rows[k].ofs, rows[k].wd, q);
            i_mcu.acc(1'b0, rows[k].nb, rows[k].ofs, 8'h00, q);
            chk(q, rows[k].ex);
        end
        mark = nrst;
        wr(8'h11, 8'h12);
        gap(2);
        chk(8'(nrst - mark), 8'h01);
        mark = nrst;
        n = 0;
        while (nrst == mark && n < 400)
        begin
            gap(1);
            n++;
        end
        chk(8'(n > 180 && n < 220), 8'h01);
        wr(8'h10, 8'h01);
        wr(8'h11, 8'hAA);
        gap(12);
        rdb(6, 1'b0);
        gap(10);
        rdb(6, 1'b1);
        mark = nrst;
        wr(8'h11, 8'h55);
        gap(25);
        wr(8'h11, 8'hAA);
        gap(4);
        chk(8'(nrst - mark), 8'h00);
        wr(8'h11, 8'h55);
        gap(2);
        chk(8'(nrst - mark), 8'h01);
        rdb(6, 1'b1);
        mark = nrst;
        wr(8'h11, 8'hAA);
        gap(50);
        chk(8'(nrst - mark), 8'h01);
        nm = 1'b0;
        sm = 1'b1;
        mark = nrst;
        gap(3);
        rdb(7, 1'b1);
        // The last key written was 0xAA, so a cleared register proves the low power clear.
        i_mcu.acc(1'b0, 1'b0, 8'h11, 8'h00, q);
        chk(q, 8'h00);
        gap(300);
        nm = 1'b1;
        sm = 1'b0;
        wr(8'h11, 8'hAA);
        gap(4);
        chk(8'(nrst - mark), 8'h00);
        tv = 1'b1;
        gap(8);
        rdb(7, 1'b1);
        wr(8'h11, 8'h12);
        gap(60);
        chk(8'(nrst - mark), 8'h00);
        tv = 1'b0;
        gap(8);
        rdb(6, 1'b1);
        // A reset in mid-run must bring back the initial phase and a cleared timeout select.
        wr(8'h10, 8'h03);
        gap(1);
        i_rst_n = 1'b0;
        gap(2);
        i_rst_n = 1'b1;
        i_mcu.acc(1'b0, 1'b0, 8'h10, 8'h00, q);
        chk(q, 8'h40);
        summarize();
    end
endmodule
bind wwd_window_watchdog wwd_properties #(.INITIAL_TIMEOUT_CYCLES(INITIAL_TIMEOUT_CYCLES),
    .BASE_TIMEOUT_CYCLES(BASE_TIMEOUT_CYCLES)) i_props (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_req(i_req), .i_normal_mode(i_normal_mode), .i_stop_mode(i_stop_mode),
    .i_test_disable_voltage(i_test_disable_voltage), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_wd_reset(o_wd_reset));
